// file: hw/oar_alarm.v
// One concentration alarm channel with direction, latch, failsafe and defeat.
`timescale 1ns/10ps
module oar_alarm
(
    input wire clk,
    input wire rst,
    input wire [19:0] conc,
    input wire [19:0] setpoint,
    input wire high_dir,
    input wire latch_sel,
    input wire failsafe_sel,
    input wire defeat_sel,
    output reg active_q,
    output reg relay_q
);
    reg latch_prev_q;
    reg defeat_prev_q;
    reg active_d;
    wire trip;
    wire clear_evt;

    assign trip = high_dir ? (conc > setpoint) : (conc < setpoint);
    assign clear_evt = (defeat_prev_q & ~defeat_sel) | (~latch_prev_q & latch_sel);

    always @*
    begin
        active_d = active_q;
        if (defeat_sel)
            active_d = 1'b0;
        else if (trip)
            active_d = 1'b1;
        else if (!latch_sel)
            active_d = 1'b0;
        else if (clear_evt)
            active_d = 1'b0;
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            active_q <= 1'b0;
            relay_q <= 1'b0;
            latch_prev_q <= 1'b0;
            defeat_prev_q <= 1'b0;
        end
        else
        begin
            active_q <= active_d;
            relay_q <= failsafe_sel ^ active_d;
            latch_prev_q <= latch_sel;
            defeat_prev_q <= defeat_sel;
        end
    end
endmodule

// file: hw/oar_scale.v
// Percent-of-range analog code and range identification code.
`timescale 1ns/10ps
`include "oar_defs.vh"
module oar_scale
(
    input wire clk,
    input wire rst,
    input wire [19:0] conc,
    input wire [19:0] limit,
    input wire [1:0] rng,
    output reg [11:0] conc_code_q,
    output reg [11:0] rid_code_q
);
    wire [31:0] prod;
    wire [31:0] quot;

    assign prod = {12'h000, conc} * 32'd4095;
    assign quot = (limit == 20'h00000) ? 32'h00000000 : prod / {12'h000, limit};

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            conc_code_q <= 12'h000;
            rid_code_q <= `OAR_RID_LO;
        end
        else
        begin
            if (conc >= limit)
                conc_code_q <= `OAR_DAC_FS;
            else
                conc_code_q <= quot[11:0];
            case (rng)
                `OAR_RNG_LO: rid_code_q <= `OAR_RID_LO;
                `OAR_RNG_MED: rid_code_q <= `OAR_RID_MED;
                default: rid_code_q <= `OAR_RID_HI;
            endcase
        end
    end
endmodule

// file: hw/oar_top.v
// Span calibration checks, concentration alarms and autoranging output control.
`timescale 1ns/10ps
`include "oar_defs.vh"
// How it works
// - At span end check raw cell output; refuse span if below minimum.
// - Refused span restores previous calibration values and raises system alarm.
// - Refused span shows failure message five seconds, then returns to analyze.
// - Failure sets persistent flag and system alarm, cleared only by standby cycle.
// - Two configurable concentration alarms plus system alarm, each with relay.
// - High alarm trips above setpoint; low alarm trips below setpoint.
// - Failsafe de-energizes relay in alarm; otherwise relay energizes in alarm.
// - Latching alarm stays active after concentration recovers until reset.
// - Non-latching alarm clears as soon as concentration recovers.
// - Defeated alarm never activates.
// - Setpoints held in ppm, zero to 10000.00 with two decimals.
// - Latched alarm clears on defeat on-off or latching off-on toggle.
// - Three range limits start at zero; unset ones use 10, 100, 250 ppm.
// - Autorange moves up when concentration exceeds current range limit.
// - Autorange moves down only below 85 percent of lower range.
// - Range change updates percent-of-range output and range identification.
// - Fixed range clamps analog output at full scale above limit.
// - Display and serial report carry true full-precision concentration.
// - Range limits accepted only when strictly increasing low to high.
// - Range mode is automatic or fixed low, medium or high.
// - Factory default load sets range mode to automatic.
// - Manual span confirm forces span reading to entered value, then analyze.
// - Range identification is quarter, half, three quarters of full scale.
module oar_top
#(
    parameter FAIL_MSG_CYCLES = `OAR_FAIL_MSG_MS * `OAR_CLK_KHZ,
    parameter [15:0] RAW_MIN = `OAR_RAW_MIN
)
(
    input wire CLK,
    input wire RST,
    input wire [19:0] CONC,
    input wire STANDBY_PIN,
    input wire SYS_FAULT,
    input wire SPAN_BEGIN,
    input wire SPAN_DONE,
    input wire SPAN_MANUAL,
    input wire [19:0] SPAN_VALUE,
    input wire [15:0] SPAN_GAIN_NEW,
    input wire [15:0] RAW_CELL,
    input wire [1:0] ALM_SET_WR,
    input wire [19:0] ALM_SET_IN,
    input wire [1:0] ALM_HIGH,
    input wire [1:0] ALM_LATCH,
    input wire [1:0] ALM_FAILSAFE,
    input wire [1:0] ALM_DEFEAT,
    input wire RANGE_WR,
    input wire [19:0] RANGE_LO_IN,
    input wire [19:0] RANGE_MED_IN,
    input wire [19:0] RANGE_HI_IN,
    input wire MODE_WR,
    input wire [1:0] MODE_IN,
    input wire FACTORY_LOAD,
    output reg [1:0] CAL_STATE,
    output reg SPAN_FAIL_MSG,
    output reg CAL_FAIL_FLAG,
    output reg SYS_ALARM,
    output reg SYS_RELAY,
    output reg [15:0] CAL_GAIN,
    output reg [19:0] SPAN_READING,
    output wire [1:0] ALARM_ACTIVE,
    output wire [1:0] ALARM_RELAY,
    output reg [19:0] CONC_REPORT,
    output reg [1:0] RANGE_SEL,
    output reg [1:0] RANGE_MODE,
    output reg RANGE_REJECT,
    output wire [11:0] CONC_CODE,
    output wire [11:0] RANGE_ID_CODE
);
    localparam integer FAIL_LAST_INT = FAIL_MSG_CYCLES - 1;
    localparam [26:0] FAIL_LAST = FAIL_LAST_INT[26:0];

    //------------------------------------------------------------
    // Standby key synchroniser
    //------------------------------------------------------------
    reg stby_m_q;
    reg stby_s_q;
    reg stby_prev_q;
    wire stby_enter;

    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            stby_m_q <= 1'b0;
            stby_s_q <= 1'b0;
            stby_prev_q <= 1'b0;
        end
        else
        begin
            stby_m_q <= STANDBY_PIN;
            stby_s_q <= stby_m_q;
            stby_prev_q <= stby_s_q;
        end
    end

    assign stby_enter = stby_s_q & ~stby_prev_q;

    //------------------------------------------------------------
    // Span calibration sequence
    //------------------------------------------------------------
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [26:0] msg_cnt_q;
    reg [15:0] gain_bak_q;
    reg fail_evt;
    wire raw_low;

    assign raw_low = RAW_CELL < RAW_MIN;

    always @*
    begin
        st_d = st_q;
        fail_evt = 1'b0;
        case (st_q)
            `OAR_ST_ANALYZE:
            begin
                if (SPAN_BEGIN)
                    st_d = `OAR_ST_SPAN;
            end
            `OAR_ST_SPAN:
            begin
                if (SPAN_DONE && raw_low)
                begin
                    fail_evt = 1'b1;
                    st_d = `OAR_ST_FAIL;
                end
                else if (SPAN_DONE)
                    st_d = `OAR_ST_ANALYZE;
            end
            `OAR_ST_FAIL:
            begin
                if (msg_cnt_q == FAIL_LAST)
                    st_d = `OAR_ST_ANALYZE;
            end
            default: st_d = `OAR_ST_ANALYZE;
        endcase
    end

    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            st_q <= `OAR_ST_ANALYZE;
            msg_cnt_q <= 27'h0000000;
            gain_bak_q <= 16'h0000;
            CAL_GAIN <= 16'h0000;
            SPAN_READING <= 20'h00000;
            CAL_STATE <= `OAR_ST_ANALYZE;
            SPAN_FAIL_MSG <= 1'b0;
            CAL_FAIL_FLAG <= 1'b0;
            SYS_ALARM <= 1'b0;
            SYS_RELAY <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            CAL_STATE <= st_d;
            SPAN_FAIL_MSG <= (st_d == `OAR_ST_FAIL);
            if (st_q == `OAR_ST_FAIL)
                msg_cnt_q <= msg_cnt_q + 27'h0000001;
            else
                msg_cnt_q <= 27'h0000000;
            if (st_q == `OAR_ST_ANALYZE && SPAN_BEGIN)
                gain_bak_q <= CAL_GAIN;
            if (fail_evt)
                CAL_GAIN <= gain_bak_q;
            else if (st_q == `OAR_ST_SPAN)
                CAL_GAIN <= SPAN_GAIN_NEW;
            if (st_q == `OAR_ST_SPAN && SPAN_DONE && !raw_low && SPAN_MANUAL)
                SPAN_READING <= SPAN_VALUE;
            if (fail_evt)
                CAL_FAIL_FLAG <= 1'b1;
            else if (stby_enter)
                CAL_FAIL_FLAG <= 1'b0;
            SYS_ALARM <= SYS_FAULT | fail_evt | (CAL_FAIL_FLAG & ~stby_enter);
            SYS_RELAY <= SYS_FAULT | fail_evt | (CAL_FAIL_FLAG & ~stby_enter);
        end
    end

    //------------------------------------------------------------
    // Concentration alarms
    //------------------------------------------------------------
    reg [19:0] setp_q [0:1];
    genvar gi;

    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_alm
            always @(posedge CLK or posedge RST)
            begin
                if (RST)
                    setp_q[gi] <= 20'h00000;
                else if (ALM_SET_WR[gi])
                    setp_q[gi] <= (ALM_SET_IN > `OAR_SETPOINT_MAX) ?
                        `OAR_SETPOINT_MAX : ALM_SET_IN;
            end

            oar_alarm u_alarm
            (
                .clk(CLK),
                .rst(RST),
                .conc(CONC),
                .setpoint(setp_q[gi]),
                .high_dir(ALM_HIGH[gi]),
                .latch_sel(ALM_LATCH[gi]),
                .failsafe_sel(ALM_FAILSAFE[gi]),
                .defeat_sel(ALM_DEFEAT[gi]),
                .active_q(ALARM_ACTIVE[gi]),
                .relay_q(ALARM_RELAY[gi])
            );
        end
    endgenerate

    //------------------------------------------------------------
    // Range limits and mode
    //------------------------------------------------------------
    reg [19:0] lim_lo_q;
    reg [19:0] lim_md_q;
    reg [19:0] lim_hi_q;
    wire [19:0] eff_lo;
    wire [19:0] eff_md;
    wire [19:0] eff_hi;
    wire [19:0] new_lo;
    wire [19:0] new_md;
    wire [19:0] new_hi;
    wire lim_ok;

    assign eff_lo = (lim_lo_q == 20'h00000) ? `OAR_DEF_LIM_LO : lim_lo_q;
    assign eff_md = (lim_md_q == 20'h00000) ? `OAR_DEF_LIM_MED : lim_md_q;
    assign eff_hi = (lim_hi_q == 20'h00000) ? `OAR_DEF_LIM_HI : lim_hi_q;
    assign new_lo = (RANGE_LO_IN == 20'h00000) ? `OAR_DEF_LIM_LO : RANGE_LO_IN;
    assign new_md = (RANGE_MED_IN == 20'h00000) ? `OAR_DEF_LIM_MED : RANGE_MED_IN;
    assign new_hi = (RANGE_HI_IN == 20'h00000) ? `OAR_DEF_LIM_HI : RANGE_HI_IN;
    assign lim_ok = (new_lo < new_md) && (new_md < new_hi);

    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            lim_lo_q <= 20'h00000;
            lim_md_q <= 20'h00000;
            lim_hi_q <= 20'h00000;
            RANGE_MODE <= `OAR_MODE_AUTO;
            RANGE_REJECT <= 1'b0;
        end
        else if (FACTORY_LOAD)
        begin
            lim_lo_q <= 20'h00000;
            lim_md_q <= 20'h00000;
            lim_hi_q <= 20'h00000;
            RANGE_MODE <= `OAR_MODE_AUTO;
            RANGE_REJECT <= 1'b0;
        end
        else
        begin
            if (RANGE_WR)
            begin
                RANGE_REJECT <= ~lim_ok;
                if (lim_ok)
                begin
                    lim_lo_q <= RANGE_LO_IN;
                    lim_md_q <= RANGE_MED_IN;
                    lim_hi_q <= RANGE_HI_IN;
                end
            end
            if (MODE_WR)
                RANGE_MODE <= MODE_IN;
        end
    end

    //------------------------------------------------------------
    // Range selection
    //------------------------------------------------------------
    reg [1:0] rng_d;
    reg [19:0] lim_cur;
    reg [19:0] lim_below;
    wire [26:0] conc_pct;
    wire [26:0] below_pct;

    always @*
    begin
        case (RANGE_SEL)
            `OAR_RNG_LO: lim_cur = eff_lo;
            `OAR_RNG_MED: lim_cur = eff_md;
            default: lim_cur = eff_hi;
        endcase
        lim_below = (RANGE_SEL == `OAR_RNG_HI) ? eff_md : eff_lo;
    end

    assign conc_pct = {7'h00, CONC} * `OAR_PCT_FULL;
    assign below_pct = {7'h00, lim_below} * `OAR_DOWN_PCT;

    always @*
    begin
        rng_d = RANGE_SEL;
        if (RANGE_MODE != `OAR_MODE_AUTO)
            rng_d = RANGE_MODE - 2'h1;
        else if (RANGE_SEL != `OAR_RNG_HI && CONC > lim_cur)
            rng_d = RANGE_SEL + 2'h1;
        else if (RANGE_SEL != `OAR_RNG_LO && conc_pct < below_pct)
            rng_d = RANGE_SEL - 2'h1;
    end

    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            RANGE_SEL <= `OAR_RNG_LO;
            CONC_REPORT <= 20'h00000;
        end
        else
        begin
            RANGE_SEL <= rng_d;
            CONC_REPORT <= CONC;
        end
    end

    oar_scale u_scale
    (
        .clk(CLK),
        .rst(RST),
        .conc(CONC),
        .limit(lim_cur),
        .rng(RANGE_SEL),
        .conc_code_q(CONC_CODE),
        .rid_code_q(RANGE_ID_CODE)
    );
endmodule

// file: shared/oar_defs.vh
// Constants shared by the oxygen alarm and autorange logic.
`ifndef OAR_DEFS_VH
`define OAR_DEFS_VH
// Span calibration sequence states.
`define OAR_ST_ANALYZE 2'h0
`define OAR_ST_SPAN 2'h1
`define OAR_ST_FAIL 2'h2
// Analog range mode choices.
`define OAR_MODE_AUTO 2'h0
`define OAR_MODE_FIXED_LOW_RANGE_MODE 2'h1
`define OAR_MODE_FIXED_MEDIUM_RANGE_MODE 2'h2
`define OAR_MODE_FIXED_HIGH_RANGE_MODE 2'h3
// Range indices.
`define OAR_RNG_LO 2'h0
`define OAR_RNG_MED 2'h1
`define OAR_RNG_HI 2'h2
// Concentrations are in hundredths of a ppm.
`define OAR_DEF_LIM_LO 20'h003E8
`define OAR_DEF_LIM_MED 20'h02710
`define OAR_DEF_LIM_HI 20'h061A8
`define OAR_SETPOINT_MAX 20'hF4240
// Downshift threshold in percent of the lower range.
`define OAR_DOWN_PCT 27'h0000055
`define OAR_PCT_FULL 27'h0000064
// Span failure message time, clock rate and raw cell minimum.
`define OAR_FAIL_MSG_MS 5000
`define OAR_CLK_KHZ 20000
`define OAR_RAW_MIN 16'h0100
// Analog output codes.
`define OAR_DAC_FS 12'hFFF
`define OAR_RID_LO 12'h400
`define OAR_RID_MED 12'h800
`define OAR_RID_HI 12'hC00
`endif

// file: verification/oar_chk.sv
// Port-level assertions for the alarm and autorange top.
`timescale 1ns/10ps
`include "oar_defs.vh"
module oar_chk
#(
    parameter FAIL_MSG_CYCLES = 20,
    parameter [15:0] RAW_MIN = `OAR_RAW_MIN
)
(
    input wire CLK,
    input wire RST,
    input wire [19:0] CONC,
    input wire SPAN_DONE,
    input wire [15:0] RAW_CELL,
    input wire [1:0] ALM_SET_WR,
    input wire [19:0] ALM_SET_IN,
    input wire [1:0] ALM_HIGH,
    input wire [1:0] ALM_LATCH,
    input wire [1:0] ALM_FAILSAFE,
    input wire [1:0] ALM_DEFEAT,
    input wire [1:0] CAL_STATE,
    input wire SPAN_FAIL_MSG,
    input wire CAL_FAIL_FLAG,
    input wire SYS_ALARM,
    input wire [1:0] ALARM_ACTIVE,
    input wire [1:0] ALARM_RELAY,
    input wire [19:0] CONC_REPORT,
    input wire [1:0] RANGE_SEL,
    input wire [1:0] RANGE_MODE,
    input wire [11:0] RANGE_ID_CODE
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    reg [19:0] sp0_q;
    integer fail_cnt_q;
    wire trip0 = ALM_HIGH[0] ? (CONC > sp0_q) : (CONC < sp0_q);
    // The stored setpoint is not a port, so it is mirrored here with the same clamp.
    always @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            sp0_q <= 20'h00000;
            fail_cnt_q <= 0;
        end
        else
        begin
            if (ALM_SET_WR[0])
                sp0_q <= (ALM_SET_IN > `OAR_SETPOINT_MAX) ? `OAR_SETPOINT_MAX : ALM_SET_IN;
            fail_cnt_q <= (CAL_STATE == `OAR_ST_FAIL) ? fail_cnt_q + 1 : 0;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    AST_FAIL_SET: assert property (
        CAL_STATE == `OAR_ST_SPAN && SPAN_DONE && RAW_CELL < RAW_MIN |=>
        CAL_STATE == `OAR_ST_FAIL && SPAN_FAIL_MSG && CAL_FAIL_FLAG && SYS_ALARM)
        else $error("low raw span was not refused");
    AST_FAIL_TIME: assert property (
        $past(CAL_STATE) == `OAR_ST_FAIL && CAL_STATE != `OAR_ST_FAIL |->
        fail_cnt_q == FAIL_MSG_CYCLES && CAL_STATE == `OAR_ST_ANALYZE && !SPAN_FAIL_MSG)
        else $error("failure message time wrong");
    AST_TRIP: assert property (
        !ALM_DEFEAT[0] && trip0 |=> ALARM_ACTIVE[0])
        else $error("alarm did not trip");
    AST_NOLATCH: assert property (
        !ALM_LATCH[0] && !trip0 |=> !ALARM_ACTIVE[0])
        else $error("unlatched alarm did not clear");
    AST_LATCH: assert property (
        ALM_LATCH[0] && $past(ALM_LATCH[0]) && !ALM_DEFEAT[0] && !$past(ALM_DEFEAT[0])
        && ALARM_ACTIVE[0] |=> ALARM_ACTIVE[0])
        else $error("latched alarm dropped");
    AST_DEFEAT: assert property (
        ALM_DEFEAT[1] |=> !ALARM_ACTIVE[1] && ALARM_RELAY[1] == $past(ALM_FAILSAFE[1]))
        else $error("defeated alarm not at rest");
    AST_RELAY: assert property (
        !$past(RST) |-> ALARM_RELAY == ($past(ALM_FAILSAFE) ^ ALARM_ACTIVE))
        else $error("relay drive wrong");
    AST_REPORT: assert property (
        !$past(RST) |-> CONC_REPORT == $past(CONC))
        else $error("report differs from concentration");
    AST_RID: assert property (
        !$past(RST) |-> RANGE_ID_CODE == ($past(RANGE_SEL) == `OAR_RNG_HI ? `OAR_RID_HI :
        $past(RANGE_SEL) == `OAR_RNG_MED ? `OAR_RID_MED : `OAR_RID_LO))
        else $error("range id code wrong");
    AST_FIXED: assert property (
        RANGE_MODE != `OAR_MODE_AUTO |=> RANGE_SEL == $past(RANGE_MODE) - 2'h1)
        else $error("fixed mode range wrong");
endmodule

// file: verification/oar_panel.sv
// Relay contact and analog meter model on the far side of the block.
`timescale 1ns/10ps
module oar_panel
(
    input wire [1:0] coil,
    input wire [11:0] conc_code,
    output wire [1:0] contact_closed,
    output wire [9:0] conc_mv
);
    // The normally open pair closes only while the coil is energized.
    assign contact_closed = coil;
    // Full scale reads 1000 mV; the meter truncates rather than rounds.
    assign conc_mv = 10'((32'(conc_code) * 1000) / 4095);
endmodule

// file: verification/tb_oar_top.sv
// Self-checking bench for the alarm and autorange top.
`timescale 1ns/10ps
`include "oar_defs.vh"
module tb_oar_top;
    localparam FMC = 20;
    reg CLK = 1'b0, RST = 1'b1, STANDBY_PIN = 1'b0, SPAN_BEGIN = 1'b0, SPAN_DONE = 1'b0;
    reg SPAN_MANUAL = 1'b0, RANGE_WR = 1'b0, MODE_WR = 1'b0, FACTORY_LOAD = 1'b0;
    reg [19:0] CONC = 20'h0, SPAN_VALUE = 20'h0, ALM_SET_IN = 20'h0;
    reg SYS_FAULT = 1'b0;
    reg [19:0] RANGE_LO_IN = 20'h0, RANGE_MED_IN = 20'h0, RANGE_HI_IN = 20'h0;
    reg [15:0] SPAN_GAIN_NEW = 16'h0, RAW_CELL = 16'h0, g1;
    reg [1:0] ALM_SET_WR = 2'h0, ALM_HIGH = 2'h0, ALM_LATCH = 2'h0, ALM_FAILSAFE = 2'h0;
    reg [1:0] ALM_DEFEAT = 2'h3, MODE_IN = 2'h0;
    reg [19:0] sp;
    reg ea;
    wire SPAN_FAIL_MSG, CAL_FAIL_FLAG, SYS_ALARM, SYS_RELAY, RANGE_REJECT;
    wire [1:0] CAL_STATE, ALARM_ACTIVE, ALARM_RELAY, RANGE_SEL, RANGE_MODE, contact;
    wire [15:0] CAL_GAIN;
    wire [19:0] SPAN_READING, CONC_REPORT;
    wire [11:0] CONC_CODE, RANGE_ID_CODE;
    wire [9:0] mv;
    integer errors = 0, comparisons = 0, i;
    int cv[7] = '{500, 1001, 900, 849, 30000, 8500, 8499};
    int ev[7] = '{0, 1, 1, 0, 2, 2, 1};
    always #25 CLK = ~CLK;
    oar_top #(.FAIL_MSG_CYCLES(FMC)) dut_u (.CLK(CLK), .RST(RST), .CONC(CONC),
        .STANDBY_PIN(STANDBY_PIN), .SYS_FAULT(SYS_FAULT), .SPAN_BEGIN(SPAN_BEGIN),
        .SPAN_DONE(SPAN_DONE), .SPAN_MANUAL(SPAN_MANUAL), .SPAN_VALUE(SPAN_VALUE),
        .SPAN_GAIN_NEW(SPAN_GAIN_NEW), .RAW_CELL(RAW_CELL), .ALM_SET_WR(ALM_SET_WR),
        .ALM_SET_IN(ALM_SET_IN), .ALM_HIGH(ALM_HIGH), .ALM_LATCH(ALM_LATCH),
        .ALM_FAILSAFE(ALM_FAILSAFE), .ALM_DEFEAT(ALM_DEFEAT), .RANGE_WR(RANGE_WR),
        .RANGE_LO_IN(RANGE_LO_IN), .RANGE_MED_IN(RANGE_MED_IN), .RANGE_HI_IN(RANGE_HI_IN),
        .MODE_WR(MODE_WR), .MODE_IN(MODE_IN), .FACTORY_LOAD(FACTORY_LOAD),
        .CAL_STATE(CAL_STATE), .SPAN_FAIL_MSG(SPAN_FAIL_MSG), .CAL_FAIL_FLAG(CAL_FAIL_FLAG),
        .SYS_ALARM(SYS_ALARM), .SYS_RELAY(SYS_RELAY), .CAL_GAIN(CAL_GAIN),
        .SPAN_READING(SPAN_READING), .ALARM_ACTIVE(ALARM_ACTIVE), .ALARM_RELAY(ALARM_RELAY),
        .CONC_REPORT(CONC_REPORT), .RANGE_SEL(RANGE_SEL), .RANGE_MODE(RANGE_MODE),
        .RANGE_REJECT(RANGE_REJECT), .CONC_CODE(CONC_CODE), .RANGE_ID_CODE(RANGE_ID_CODE));
    oar_panel panel_u (.coil(ALARM_RELAY), .conc_code(CONC_CODE), .contact_closed(contact),
        .conc_mv(mv));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input string name, input [19:0] seen, input [19:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("Error %0s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge CLK);
    endtask
    function [19:0] code(input [19:0] c, input [19:0] l);
        code = (c >= l) ? 20'hFFF : 20'((c * 4095) / l);
    endfunction
    function [19:0] dl(input int r);
        dl = r == 0 ? `OAR_DEF_LIM_LO : r == 1 ? `OAR_DEF_LIM_MED : `OAR_DEF_LIM_HI;
    endfunction
    task span(input [15:0] raw, input man);
    begin
        SPAN_BEGIN = 1'b1;
        cyc(1);
        SPAN_BEGIN = 1'b0;
        SPAN_GAIN_NEW = 16'($urandom);
        SPAN_MANUAL = man;
        RAW_CELL = raw;
        cyc(3);
        SPAN_DONE = 1'b1;
        cyc(1);
        SPAN_DONE = 1'b0;
    end
    endtask
    task rng(input [19:0] lo, input [19:0] md, input [19:0] hi, input rej);
    begin
        RANGE_LO_IN = lo;
        RANGE_MED_IN = md;
        RANGE_HI_IN = hi;
        RANGE_WR = 1'b1;
        cyc(1);
        RANGE_WR = 1'b0;
        chk("reject", RANGE_REJECT, rej);
    end
    endtask
    task finish_test;
    begin
        if (errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        #(50 * 3000);
        errors = errors + 1;
        finish_test;
    end
    initial
    begin
        sp = 20'($urandom(32'h1052));
        cyc(20);
        RST = 1'b0;
        ALM_SET_IN = 20'hFFFFF;
        ALM_SET_WR = 2'h1;
        cyc(1);
        ALM_SET_WR = 2'h0;
        ALM_DEFEAT = 2'h2;
        ALM_HIGH = 2'h1;
        CONC = `OAR_SETPOINT_MAX;
        cyc(1);
        chk("alm0 at max", ALARM_ACTIVE[0], 1'b0);
        CONC = 20'hF4241;
        ALM_LATCH = 2'h1;
        cyc(1);
        chk("alm0 over", ALARM_ACTIVE[0], 1'b1);
        CONC = 20'h0;
        cyc(2);
        chk("alm0 held", ALARM_ACTIVE[0], 1'b1);
        ALM_DEFEAT = 2'h3;
        cyc(1);
        ALM_DEFEAT = 2'h2;
        cyc(2);
        chk("alm0 dft clr", ALARM_ACTIVE[0], 1'b0);
        CONC = 20'hF4241;
        cyc(1);
        CONC = 20'h0;
        ALM_LATCH = 2'h0;
        cyc(1);
        ALM_LATCH = 2'h1;
        cyc(2);
        chk("alm0 ltch clr", ALARM_ACTIVE[0], 1'b0);
        sp = 20'($urandom_range(4000));
        ALM_SET_IN = sp;
        ALM_SET_WR = 2'h2;
        cyc(1);
        ALM_SET_WR = 2'h0;
        for (i = 0; i < 60; i = i + 1)
        begin
            CONC = 20'($urandom_range(4000));
            {ALM_HIGH[1], ALM_FAILSAFE[1], ALM_DEFEAT[1]} = 3'($urandom);
            cyc(1);
            ea = !ALM_DEFEAT[1] && (ALM_HIGH[1] ? CONC > sp : CONC < sp);
            chk("alm1 act", ALARM_ACTIVE[1], ea);
            chk("alm1 contact", contact[1], ALM_FAILSAFE[1] ^ ea);
            chk("report", CONC_REPORT, CONC);
        end
        span(16'h0100, 1'b0);
        g1 = SPAN_GAIN_NEW;
        chk("state", CAL_STATE, `OAR_ST_ANALYZE);
        chk("gain", CAL_GAIN, g1);
        chk("auto reading", SPAN_READING, 20'h0);
        span(16'h00FF, 1'b1);
        chk("state", CAL_STATE, `OAR_ST_FAIL);
        chk("gain", CAL_GAIN, g1);
        chk("fail bits", {SPAN_FAIL_MSG, CAL_FAIL_FLAG, SYS_ALARM, SYS_RELAY}, 4'hF);
        cyc(FMC - 1);
        chk("state", CAL_STATE, `OAR_ST_FAIL);
        cyc(1);
        chk("msg end", {CAL_STATE, SPAN_FAIL_MSG, CAL_FAIL_FLAG}, 4'h1);
        SPAN_VALUE = 20'h00320;
        span(16'h0200, 1'b1);
        chk("reading", SPAN_READING, 20'h00320);
        chk("state", CAL_STATE, `OAR_ST_ANALYZE);
        chk("flag kept", {CAL_FAIL_FLAG, SYS_ALARM}, 2'h3);
        STANDBY_PIN = 1'b1;
        cyc(2);
        STANDBY_PIN = 1'b0;
        cyc(4);
        chk("flag clr", {CAL_FAIL_FLAG, SYS_ALARM}, 2'h0);
        SYS_FAULT = 1'b1;
        cyc(1);
        chk("sys fault", {SYS_ALARM, SYS_RELAY}, 2'h3);
        SYS_FAULT = 1'b0;
        cyc(1);
        chk("sys idle", {SYS_ALARM, SYS_RELAY}, 2'h0);
        for (i = 0; i < 7; i = i + 1)
        begin
            CONC = 20'(cv[i]);
            cyc(4);
            chk("range sel", RANGE_SEL, 20'(ev[i]));
            chk("conc code", CONC_CODE, code(CONC, dl(ev[i])));
            chk("range id", RANGE_ID_CODE, 20'(12'h400 * (ev[i] + 1)));
        end
        for (i = 1; i < 4; i = i + 1)
        begin
            MODE_IN = 2'(i);
            MODE_WR = 1'b1;
            cyc(1);
            MODE_WR = 1'b0;
            CONC = 20'h07530;
            cyc(4);
            chk("mode", RANGE_MODE, 20'(i));
            chk("fixed sel", RANGE_SEL, 20'(i - 1));
            chk("meter mv", mv, 20'd1000);
            FACTORY_LOAD = 1'b1;
            cyc(1);
            FACTORY_LOAD = 1'b0;
            chk("factory", RANGE_MODE, `OAR_MODE_AUTO);
        end
        rng(20'h01388, 20'h00BB8, 20'h00000, 1'b1);
        rng(20'h007D0, 20'h00000, 20'h00000, 1'b0);
        rng(20'h007D0, 20'h02710, 20'h01388, 1'b1);
        CONC = 20'h005DC;
        cyc(4);
        chk("prog sel", RANGE_SEL, `OAR_RNG_LO);
        chk("prog code", CONC_CODE, code(CONC, 20'h007D0));
        finish_test;
    end
endmodule
bind oar_top oar_chk #(.FAIL_MSG_CYCLES(FAIL_MSG_CYCLES), .RAW_MIN(RAW_MIN)) chk_u (
    .CLK(CLK), .RST(RST), .CONC(CONC), .SPAN_DONE(SPAN_DONE), .RAW_CELL(RAW_CELL),
    .ALM_SET_WR(ALM_SET_WR), .ALM_SET_IN(ALM_SET_IN), .ALM_HIGH(ALM_HIGH),
    .ALM_LATCH(ALM_LATCH), .ALM_FAILSAFE(ALM_FAILSAFE), .ALM_DEFEAT(ALM_DEFEAT),
    .CAL_STATE(CAL_STATE), .SPAN_FAIL_MSG(SPAN_FAIL_MSG), .CAL_FAIL_FLAG(CAL_FAIL_FLAG),
    .SYS_ALARM(SYS_ALARM), .ALARM_ACTIVE(ALARM_ACTIVE), .ALARM_RELAY(ALARM_RELAY),
    .CONC_REPORT(CONC_REPORT), .RANGE_SEL(RANGE_SEL), .RANGE_MODE(RANGE_MODE),
    .RANGE_ID_CODE(RANGE_ID_CODE));
